// file: hw/kms_top.sv
// key matrix scanner with reset sequencing, frame rate and port four clock
// assumes: sense inputs and chip enable synchronous to clk_i, axi4-lite host
`timescale 1ns/1ps

// Summary of operation
// - one matrix scan lasts 2304 clocks
// - two scans must agree before accepting
// - request goes low 4800 clocks after start
// - disagreement with key held restarts scans
// - scan starts on press, repeats until release
// - low scan lines never carry pulses
// - every pressed key on a high scan line sets its bit
// - chip enable high releases the request
// - reading key data clears request, rescans
// - press in sleep wakes clock, scans
// - key read leaves sleep mode unchanged
// - eight rows: divide 3072 or 1536
// - ten rows: divide 3840 or 1920
// - port four outputs clock halves or eighths
// - supply detector forces system reset
// - reset: display off, scan off, ports low
// - technique then scan config releases scanning
// - timing held until technique instruction
// - address register reset, loaded by write
// - contrast disabled until programmed
// - reset clears key bits, scanning disabled
// - bit index is five times line plus input
// - sleep ack bit reads sleep state
module kms_top
  import kms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic supply_detect_reset_i,
  // key matrix
  output logic [5:0] scan_drive_lines_o,
  input wire logic [4:0] sense_return_inputs_i,
  // serial side
  input wire logic chip_enable_i,
  output logic request_oe_o,
  output logic request_o,
  // ports and display state
  output logic [3:0] general_ports_o,
  output logic frame_tick_o,
  output logic display_on_o,
  output logic contrast_en_o,
  output logic osc_run_o,
  // axi4-lite
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i
);

  logic sys_rst;
  logic wr;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic rd;
  logic [7:0] rd_addr;
  logic [31:0] next_rd_data;
  logic rd_err;
  logic wr_err;
  logic tech_done;
  logic scan_enabled;
  logic frame_fast;
  logic ten_rows;
  logic clock_src;
  logic sleep;
  logic [7:0] addr_counter;
  logic [4:0] contrast;
  kms_scan_cfg_s scan_cfg;
  kms_state_e state;
  logic [12:0] scan_count;
  logic [12:0] req_count;
  logic [2:0] line_idx;
  logic [29:0] scan_data;
  logic [29:0] first_data;
  logic [29:0] key_bits;
  logic req_pending;
  logic [11:0] frame_last;
  logic [11:0] p4_last;
  logic p4_clk;
  logic osc_en;
  logic any_press;

  // ****************************************
  // system reset from supply detector
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_rst <= 1'b1;
    end else begin
      sys_rst <= supply_detect_reset_i;
    end
  end

  kms_axil u_axil (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .wr_o(wr),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .rd_o(rd),
    .rd_addr_o(rd_addr),
    .rd_data_i(next_rd_data),
    .rd_err_i(rd_err),
    .wr_err_i(wr_err)
  );

  assign wr_err = !(wr_addr == KMS_CTRL_OFS || wr_addr == KMS_SCAN_OFS ||
                    wr_addr == KMS_ACK_OFS || wr_addr == KMS_CNTR_OFS);

  // ****************************************
  // instruction registers
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tech_done <= 1'b0;
      frame_fast <= 1'b0;
      ten_rows <= 1'b0;
      clock_src <= 1'b0;
      sleep <= 1'b0;
      display_on_o <= 1'b0;
      addr_counter <= 8'h00;
    end else if (sys_rst) begin
      tech_done <= 1'b0;
      display_on_o <= 1'b0;
      addr_counter <= 8'h00;
      sleep <= 1'b0;
    end else if (wr && wr_addr == KMS_CTRL_OFS) begin
      if (wr_data[KMS_CTRL_TECH_POS]) begin
        tech_done <= 1'b1;
        frame_fast <= wr_data[KMS_CTRL_FC_POS];
        ten_rows <= wr_data[KMS_CTRL_TEN_POS];
        clock_src <= wr_data[KMS_CTRL_OC_POS];
      end
      if (tech_done) begin
        sleep <= wr_data[KMS_CTRL_SLEEP_POS];
        display_on_o <= wr_data[KMS_CTRL_DISP_POS];
        addr_counter <= wr_data[KMS_CTRL_ADDR_POS +: 8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scan_enabled <= 1'b0;
      scan_cfg <= '0;
      contrast <= 5'h00;
      contrast_en_o <= 1'b0;
    end else if (sys_rst) begin
      scan_enabled <= 1'b0;
      scan_cfg <= '0;
      contrast <= 5'h00;
      contrast_en_o <= 1'b0;
    end else if (wr && tech_done) begin
      if (wr_addr == KMS_SCAN_OFS) begin
        scan_enabled <= 1'b1;
        scan_cfg.lines <= wr_data[5:0];
        scan_cfg.p4_mode <= {wr_data[KMS_SCAN_P4H_POS], wr_data[KMS_SCAN_P4L_POS]};
        scan_cfg.ports <= wr_data[KMS_SCAN_PC_POS +: 3];
      end
      if (wr_addr == KMS_CNTR_OFS) begin
        contrast <= wr_data[4:0];
        contrast_en_o <= wr_data[KMS_CNTR_CTC_POS];
      end
    end
  end

  // ****************************************
  // key scan engine
  // ****************************************
  assign any_press = |sense_return_inputs_i;
  assign osc_en = tech_done && (!sleep || state != KMS_IDLE || any_press);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= KMS_IDLE;
      scan_count <= 13'h0000;
      req_count <= 13'h0000;
      line_idx <= 3'h0;
      scan_data <= KMS_KEY_RESET;
      first_data <= KMS_KEY_RESET;
      key_bits <= KMS_KEY_RESET;
      req_pending <= 1'b0;
    end else if (sys_rst || !scan_enabled) begin
      state <= KMS_IDLE;
      key_bits <= KMS_KEY_RESET;
      req_pending <= 1'b0;
      scan_count <= 13'h0000;
      req_count <= 13'h0000;
    end else begin
      if (state != KMS_IDLE && state != KMS_REQ) begin
        req_count <= req_count + 13'h0001;
      end
      case (state)
        KMS_IDLE: begin
          if (any_press) begin
            state <= KMS_SCAN1;
            scan_count <= 13'h0000;
            req_count <= 13'h0000;
            line_idx <= 3'h0;
            scan_data <= KMS_KEY_RESET;
          end
        end
        KMS_SCAN1, KMS_SCAN2: begin
          if (scan_count == (KMS_LINE_LAST + 13'h0001) * 13'(line_idx + 3'h1) - 13'h0002 &&
              scan_cfg.lines[line_idx]) begin
            scan_data[line_idx * 5 +: 5] <= sense_return_inputs_i;
          end
          if (scan_count == (KMS_LINE_LAST + 13'h0001) * 13'(line_idx + 3'h1) - 13'h0001) begin
            line_idx <= line_idx + 3'h1;
          end
          if (scan_count == KMS_SCAN_LAST) begin
            scan_count <= 13'h0000;
            line_idx <= 3'h0;
            scan_data <= KMS_KEY_RESET;
            if (state == KMS_SCAN1) begin
              first_data <= scan_data;
              state <= KMS_SCAN2;
            end else begin
              key_bits <= scan_data;
              state <= KMS_WAIT;
            end
          end else begin
            scan_count <= scan_count + 13'h0001;
          end
        end
        KMS_WAIT: begin
          if (req_count == KMS_REQ_LAST) begin
            if (key_bits == first_data && key_bits != KMS_KEY_RESET) begin
              state <= KMS_REQ;
              req_pending <= 1'b1;
            end else if (any_press) begin
              state <= KMS_SCAN1;
              req_count <= 13'h0000;
            end else begin
              state <= KMS_IDLE;
            end
          end
        end
        KMS_REQ: begin
          if (rd && rd_addr == KMS_KEY_OFS) begin
            req_pending <= 1'b0;
            state <= KMS_IDLE;
          end
        end
        default: begin
          state <= KMS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // scan drive and request pin
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scan_drive_lines_o <= KMS_LINES_RESET;
    end else if (sys_rst || !scan_enabled) begin
      scan_drive_lines_o <= KMS_LINES_RESET;
    end else if (state == KMS_SCAN1 || state == KMS_SCAN2) begin
      scan_drive_lines_o <= scan_cfg.lines & (6'h01 << line_idx);
    end else begin
      scan_drive_lines_o <= scan_cfg.lines;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      request_oe_o <= 1'b0;
      request_o <= 1'b0;
      osc_run_o <= 1'b0;
    end else begin
      request_oe_o <= req_pending && !chip_enable_i && !sys_rst;
      request_o <= 1'b0;
      osc_run_o <= osc_en && !sys_rst;
    end
  end

  // ****************************************
  // frame rate and port four clock
  // ****************************************
  always_comb begin
    if (ten_rows) begin
      frame_last = frame_fast ? KMS_F10_FAST : KMS_F10_SLOW;
    end else begin
      frame_last = frame_fast ? KMS_F8_FAST : KMS_F8_SLOW;
    end
    p4_last = (scan_cfg.p4_mode == KMS_P4_DIV8) ? KMS_P4_DIV8_LAST : KMS_P4_DIV2_LAST;
  end

  kms_divider u_frame (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(osc_en && !sys_rst),
    .last_i(12'(frame_last >> 1)),
    .div_o(),
    .tick_o(frame_tick_o)
  );

  kms_divider u_p4 (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(osc_en && !sys_rst && scan_cfg.p4_mode[1]),
    .last_i(p4_last),
    .div_o(p4_clk),
    .tick_o()
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      general_ports_o <= 4'h0;
    end else if (sys_rst || !scan_enabled) begin
      general_ports_o <= 4'h0;
    end else begin
      general_ports_o[2:0] <= scan_cfg.ports;
      case (scan_cfg.p4_mode)
        KMS_P4_LOW: general_ports_o[3] <= 1'b0;
        KMS_P4_HIGH: general_ports_o[3] <= 1'b1;
        default: general_ports_o[3] <= p4_clk;
      endcase
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  always_comb begin
    next_rd_data = KMS_ZERO_32;
    rd_err = 1'b0;
    case (rd_addr)
      KMS_CTRL_OFS: next_rd_data = {16'h0000, addr_counter, 2'h0, display_on_o, sleep,
                                    clock_src, ten_rows, frame_fast, tech_done};
      KMS_SCAN_OFS: next_rd_data = {21'h000000, scan_cfg.ports, scan_cfg.p4_mode,
                                    scan_cfg.lines};
      KMS_KEY_OFS: next_rd_data = {sleep, 1'b0, key_bits};
      KMS_STAT_OFS: next_rd_data = {29'h00000000, scan_enabled, osc_en, req_pending};
      KMS_CNTR_OFS: next_rd_data = {26'h0000000, contrast_en_o, contrast};
      KMS_ACK_OFS: next_rd_data = KMS_ZERO_32;
      default: rd_err = 1'b1;
    endcase
  end

endmodule

// file: hw/kms_pkg.sv
// package: constants, types and register map for the key matrix scanner
// assumes: 32-bit axi4-lite register access, 10 MHz clk_i
package kms_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] KMS_CTRL_OFS = 8'h00;
  localparam logic [7:0] KMS_SCAN_OFS = 8'h04;
  localparam logic [7:0] KMS_KEY_OFS = 8'h08;
  localparam logic [7:0] KMS_ACK_OFS = 8'h0c;
  localparam logic [7:0] KMS_STAT_OFS = 8'h10;
  localparam logic [7:0] KMS_CNTR_OFS = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int KMS_CTRL_TECH_POS = 0;
  localparam int KMS_CTRL_FC_POS = 1;
  localparam int KMS_CTRL_TEN_POS = 2;
  localparam int KMS_CTRL_OC_POS = 3;
  localparam int KMS_CTRL_SLEEP_POS = 4;
  localparam int KMS_CTRL_DISP_POS = 5;
  localparam int KMS_CTRL_ADDR_POS = 8;
  localparam int KMS_SCAN_P4L_POS = 6;
  localparam int KMS_SCAN_P4H_POS = 7;
  localparam int KMS_SCAN_PC_POS = 8;
  localparam int KMS_CNTR_CTC_POS = 4;
  localparam int KMS_KEY_SA_POS = 31;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] KMS_ZERO_32 = 32'h0000_0000;
  localparam logic [29:0] KMS_KEY_RESET = 30'h0000_0000;
  localparam logic [5:0] KMS_LINES_RESET = 6'h00;

  // ****************************************
  // timing in oscillator periods
  // ****************************************
  localparam int KMS_SCAN_PERIOD_T = 2304;
  localparam int KMS_REQ_DELAY_T = 4800;
  localparam int KMS_LINE_T = KMS_SCAN_PERIOD_T / 6;
  localparam logic [12:0] KMS_SCAN_LAST = 13'(KMS_SCAN_PERIOD_T - 1);
  localparam logic [12:0] KMS_REQ_LAST = 13'(KMS_REQ_DELAY_T - 1);
  localparam logic [12:0] KMS_LINE_LAST = 13'(KMS_LINE_T - 1);
  localparam logic [11:0] KMS_F8_SLOW = 12'(3072 - 1);
  localparam logic [11:0] KMS_F8_FAST = 12'(1536 - 1);
  localparam logic [11:0] KMS_F10_SLOW = 12'(3840 - 1);
  localparam logic [11:0] KMS_F10_FAST = 12'(1920 - 1);
  localparam logic [11:0] KMS_P4_DIV2_LAST = 12'h000;
  localparam logic [11:0] KMS_P4_DIV8_LAST = 12'h003;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    KMS_P4_LOW,
    KMS_P4_HIGH,
    KMS_P4_DIV2,
    KMS_P4_DIV8
  } kms_p4_e;

  typedef enum {
    KMS_IDLE,
    KMS_SCAN1,
    KMS_SCAN2,
    KMS_WAIT,
    KMS_REQ
  } kms_state_e;

  typedef struct packed {
    logic [5:0] lines;
    logic [1:0] p4_mode;
    logic [2:0] ports;
  } kms_scan_cfg_s;

endpackage

// file: hw/kms_divider.sv
// divided clock source: toggles its output every last_i+1 cycles
// assumes: last_i stable, en_i low holds the output low
`timescale 1ns/1ps
module kms_divider
  import kms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic en_i,
  input wire logic [11:0] last_i,
  // divided output
  output logic div_o,
  output logic tick_o
);

  logic [11:0] count;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 12'h000;
      div_o <= 1'b0;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      count <= 12'h000;
      div_o <= 1'b0;
      tick_o <= 1'b0;
    end else if (count >= last_i) begin
      count <= 12'h000;
      div_o <= ~div_o;
      tick_o <= div_o;
    end else begin
      count <= count + 12'h001;
      tick_o <= 1'b0;
    end
  end

endmodule

// file: hw/kms_axil.sv
// axi4-lite slave front end: one write and one read at a time
// assumes: register file answers writes and reads in the same cycle
`timescale 1ns/1ps
module kms_axil
  import kms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // axi4-lite
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // register side
  output logic wr_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic rd_o,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i,
  input wire logic wr_err_i
);

  logic aw_held;
  logic w_held;

  assign wr_o = aw_held && w_held && !bvalid_o;
  assign rd_o = arvalid_i && arready_o;
  assign rd_addr_o = araddr_i;

  // ****************************************
  // write channels
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      wr_addr_o <= 8'h00;
      wr_data_o <= KMS_ZERO_32;
      bvalid_o <= 1'b0;
      bresp_o <= 2'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held <= 1'b1;
        awready_o <= 1'b0;
        wr_addr_o <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held <= 1'b1;
        wready_o <= 1'b0;
        wr_data_o <= wdata_i;
      end
      if (wr_o) begin
        bvalid_o <= 1'b1;
        bresp_o <= (wr_err_i || wstrb_i == 4'h0) ? 2'h2 : 2'h0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // read channels
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= KMS_ZERO_32;
      rresp_o <= 2'h0;
    end else if (rd_o) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= rd_data_i;
      rresp_o <= rd_err_i ? 2'h2 : 2'h0;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end
  end

endmodule

// file: verification/kms_top_checker.sv
// checker: request pin, supply reset and read channel relations of kms_top
// assumes: bound to kms_top, one clock domain
`timescale 1ns/1ps
module kms_top_checker
  import kms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic supply_detect_reset_i,
  // watched signals
  input wire logic chip_enable_i,
  input wire logic request_oe_o,
  input wire logic request_o,
  input wire logic [3:0] general_ports_o,
  input wire logic [5:0] scan_drive_lines_o,
  input wire logic display_on_o,
  input wire logic contrast_en_o,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i
);
  // ****************
  // cycles since key read
  // ****************
  logic key_rd;
  logic [12:0] quiet;
  assign key_rd = arvalid_i && arready_o && araddr_i == KMS_KEY_OFS;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quiet <= 13'h0000;
    end else if (key_rd || supply_detect_reset_i) begin
      quiet <= 13'h0000;
    end else if (quiet != 13'h1fff) begin
      quiet <= quiet + 13'h0001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ce_release: assert property (chip_enable_i |=> !request_oe_o)
    else $error("request held under chip enable");
  chk_pin_low: assert property (request_o == 1'b0)
    else $error("request pin driven high");
  chk_read_clear: assert property (key_rd |=> ##1 !request_oe_o)
    else $error("request kept after key read");
  chk_req_hold: assert property (request_oe_o && !chip_enable_i && !key_rd &&
    !$past(key_rd) && !supply_detect_reset_i && !$past(supply_detect_reset_i) |=> request_oe_o)
    else $error("request dropped by itself");
  chk_req_delay: assert property ($rose(request_oe_o) |-> quiet >= 13'h12c0)
    else $error("request too early");
  chk_supply_reset: assert property (supply_detect_reset_i [*2] |=>
    general_ports_o == 4'h0 && scan_drive_lines_o == 6'h00 && !display_on_o &&
    !contrast_en_o && !request_oe_o)
    else $error("supply reset state wrong");
  chk_r_hold: assert property (rvalid_o && !rready_i |=> rvalid_o)
    else $error("read data withdrawn");
  chk_ar_busy: assert property (rvalid_o |-> !arready_o)
    else $error("second read accepted");
endmodule

bind kms_top kms_top_checker i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .supply_detect_reset_i(supply_detect_reset_i), .chip_enable_i(chip_enable_i),
  .request_oe_o(request_oe_o), .request_o(request_o), .general_ports_o(general_ports_o),
  .scan_drive_lines_o(scan_drive_lines_o), .display_on_o(display_on_o),
  .contrast_en_o(contrast_en_o), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
  .arready_o(arready_o), .rvalid_o(rvalid_o), .rready_i(rready_i));

// file: verification/kms_key_matrix.sv
// key matrix model: pressed keys join driven scan lines to sense inputs
// assumes: pressed mask from the bench, bit index 5*line+input
`timescale 1ns/1ps
module kms_key_matrix
  import kms_pkg::*;
(
  // matrix side
  input wire logic [5:0] lines_i,
  input wire logic [29:0] pressed_i,
  output logic [4:0] sense_o
);
  always_comb begin
    sense_o = 5'h00;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 5; j++) begin
        if (lines_i[i] && pressed_i[5 * i + j]) begin
          sense_o[j] = 1'b1;
        end
      end
    end
  end
endmodule

// file: verification/kms_top_test.sv
// testbench: key matrix scanner driven over axi4-lite, key matrix model outside
// assumes: kms_pkg, kms_top, checker and key matrix model compiled first
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h seen %h", nm, e, a); end end
module kms_top_test;
  import kms_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, supply_detect_reset_i = 1'b0, chip_enable_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [3:0] wstrb_i = 4'hf, general_ports_o;
  logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, request_oe_o, request_o;
  logic frame_tick_o, display_on_o, contrast_en_o, osc_run_o;
  logic [1:0] bresp_o, rresp_o, r;
  logic [5:0] scan_drive_lines_o, seen;
  logic [4:0] sense_return_inputs_i;
  logic [29:0] pressed = 30'h0;
  int fail_count = 0, samples_checked = 0, cycles = 0, n;
  int divs [4] = '{3072, 1536, 3840, 1920};
  always #50 clk_i = ~clk_i;
  kms_top i_dut (.clk_i, .reset_n_i, .supply_detect_reset_i, .scan_drive_lines_o,
    .sense_return_inputs_i, .chip_enable_i, .request_oe_o, .request_o, .general_ports_o,
    .frame_tick_o, .display_on_o, .contrast_en_o, .osc_run_o, .awaddr_i, .awvalid_i,
    .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
    .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i);
  kms_key_matrix i_keys (.lines_i(scan_drive_lines_o), .pressed_i(pressed),
    .sense_o(sense_return_inputs_i));
  // ****************
  // bus and wait tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic press(input logic [29:0] k);
    @(posedge clk_i);
    pressed <= k;
  endtask
  task automatic wait_req(input int lim);
    n = 0;
    seen = 6'h00;
    while (request_oe_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
      seen |= scan_drive_lines_o;
    end
  endtask
  task automatic tick_gap;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (frame_tick_o !== 1'b1 && n < 5000);
  endtask
  task automatic p4_toggles;
    logic last;
    n = 0;
    repeat (8) @(posedge clk_i);
    last = general_ports_o[3];
    repeat (16) begin
      @(posedge clk_i);
      if (general_ports_o[3] !== last) n++;
      last = general_ports_o[3];
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(KMS_KEY_OFS);
    `CHK("key reset", 32'h0, d)
    `CHK("idle outs", 8'h00, {general_ports_o, display_on_o, contrast_en_o, osc_run_o, request_oe_o})
    rd(8'h1c);
    `CHK("unmapped", 2'h2, r)
    wr(KMS_SCAN_OFS, 32'h3f);
    `CHK("early ok", 2'h0, r)
    rd(KMS_SCAN_OFS);
    `CHK("scan early", 32'h0, d)
    wr(KMS_CTRL_OFS, 32'h1);
    wr(KMS_SCAN_OFS, 32'h5bf);
    p4_toggles();
    `CHK("p4 half", 16, n)
    `CHK("standby", 10'h37f, {osc_run_o, general_ports_o[2:0], scan_drive_lines_o})
    wr(KMS_SCAN_OFS, 32'h5ff);
    p4_toggles();
    `CHK("p4 eighth", 4, n)
    press(30'h2000_0001);
    wait_req(6000);
    `CHK("req delay", 1'b1, n >= 4800 && n <= 4820)
    chip_enable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("ce release", 1'b0, request_oe_o)
    chip_enable_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("ce back", 1'b1, request_oe_o)
    rd(KMS_KEY_OFS);
    `CHK("two keys", 32'h2000_0001, d)
    `CHK("under three", 1'b1, $countones(d[29:0]) < 3)
    `CHK("cleared", 1'b0, request_oe_o)
    wait_req(6000);
    `CHK("rescan", 1'b1, request_oe_o)
    press(30'h0);
    rd(KMS_KEY_OFS);
    wait_req(10000);
    `CHK("released", 1'b0, request_oe_o)
    press(30'h80);
    repeat (1000) @(posedge clk_i);
    press(30'h0);
    wait_req(8000);
    `CHK("short press", 1'b0, request_oe_o)
    wr(KMS_SCAN_OFS, 32'h5c1);
    press(30'h0400_0000);
    wait_req(6000);
    `CHK("low line only", 1'b0, request_oe_o)
    press(30'h0400_0004);
    wait_req(6000);
    `CHK("no pulses", 5'h00, seen[5:1])
    press(30'h0);
    rd(KMS_KEY_OFS);
    `CHK("high line key", 32'h4, d)
    for (int k = 0; k < 4; k++) begin
      wr(KMS_CTRL_OFS, 32'(2 * k + 1));
      tick_gap();
      tick_gap();
      `CHK("frame gap", divs[k], n)
    end
    wr(KMS_CTRL_OFS, 32'h11);
    repeat (4) @(posedge clk_i);
    `CHK("asleep", 1'b0, osc_run_o)
    press(30'h4);
    wait_req(6000);
    `CHK("wake", 2'h3, {osc_run_o, request_oe_o})
    press(30'h0);
    rd(KMS_KEY_OFS);
    `CHK("sleep key", 32'h8000_0004, d)
    rd(KMS_CTRL_OFS);
    `CHK("still asleep", 32'h11, d)
    wr(KMS_CNTR_OFS, 32'h10);
    wr(KMS_CTRL_OFS, 32'h5a21);
    `CHK("ctrl resp", 2'h0, r)
    rd(KMS_CTRL_OFS);
    `CHK("ctrl back", 32'h5a21, d)
    `CHK("on", 2'h3, {display_on_o, contrast_en_o})
    supply_detect_reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    supply_detect_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("supply outs", 13'h0, {general_ports_o, scan_drive_lines_o, display_on_o, contrast_en_o, osc_run_o})
    rd(KMS_CTRL_OFS);
    `CHK("ctrl reset", 32'h0, d)
    rd(KMS_KEY_OFS);
    `CHK("key cleared", 32'h0, d)
    tally_and_finish();
  end
endmodule
